// file: cpu_pc_flags_datapath.sv
// program counter and condition flags datapath with avalon register port
//
// Function
// - keep a 16-bit counter holding address of next byte to fetch.
// - advance the counter by one after each instruction or operand fetch.
// - jumps, branches, interrupts, returns load a non-sequential target.
// - after reset, load counter from two-byte vector at top of memory.
// - eight-bit flags register with bits 6 and 5 always one.
// - bit 7 flags two's complement overflow; signed branches test it.
// - bit 4 flags carry from bit 3 into bit 4 on adds.
// - decimal adjust uses half-carry and carry to correct BCD sums.
// - bit 3 is the interrupt mask; one blocks maskable interrupts.
// - taking an interrupt sets the mask after stacking registers.
// - no interrupt at the boundary right after clearing a set mask.
// - bit 2 set when result or loaded value has top bit one.
// - bit 1 set when result or loaded value is all zero.
// - bit 0 takes carry or borrow out of bit 7, shifts too.
// - one linear 64-Kbyte space addressed by 16-bit addresses.
// - moves locate source and destination by separate modes.
// - bit and compare branches fetch operand, then branch relatively.
// - inherent mode takes operands from registers, no memory access.
// - taken relative branch adds sign-extended 8-bit offset to counter.
// - interrupt entry stacks counter low, high, index, accumulator, flags.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cpu_pc_flags_datapath
   import pcflags_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // avalon-mm slave
   input  wire pcflags_pkg::avreq_t avReq,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   // cpu bus
   output logic [15:0]            busAddr,
   output logic                   busRead,
   output logic                   busWrite,
   output logic [7:0]             busWdata,
   input  wire logic [7:0]        busRdata,
   // sequencing control
   input  wire pcflags_pkg::pcop_t pcOp,
   input  wire logic [15:0]       pcTarget,
   input  wire logic [7:0]        relOffset,
   input  wire logic              branchCond,
   input  wire logic              irqReq,
   input  wire logic [15:0]       irqVector,
   input  wire logic [7:0]        indexLow,
   input  wire logic [7:0]        accum,
   input  wire logic [15:0]       stackPtr,
   // status
   output logic [15:0]            programCounter,
   output logic [7:0]             conditionFlags,
   output logic                   irqTaken,
   output logic                   signedGreater,
   output logic                   signedLess,
   output logic                   busy
);
   import pcflags_pkg::*;

   typedef enum logic [6:0]
   {
      S_VECHI = 7'b000_0001,
      S_VECLO = 7'b000_0010,
      S_RUN   = 7'b000_0100,
      S_PUSH  = 7'b000_1000,
      S_IVEC  = 7'b001_0000,
      S_IDLE  = 7'b010_0000,
      S_DONE  = 7'b100_0000
   } state_t;

   state_t      state;
   logic [2:0]  pushIdx;
   logic [7:0]  vecHigh;
   logic [7:0]  opA;
   logic [7:0]  opB;
   logic        maskShadow;
   logic        ackPend;
   aluop_t      cmdOp;
   logic        cmdGo;
   aluout_t     alu;
   logic [7:0]  lastResult;
   logic [7:0]  next_flags;
   logic        canIrq;

   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction : sext8

   function automatic logic [7:0] fixFlags(input logic [7:0] f);
      fixFlags = f | FLAGS_FIXED_ONES;
   endfunction : fixFlags

   // avalon slave: one wait cycle, then answer
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ackPend     <= 1'b0;
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
         opA         <= 8'h00;
         opB         <= 8'h00;
         cmdOp       <= OP_NONE;
         cmdGo       <= 1'b0;
      end
      else
      begin
         cmdGo <= 1'b0;
         if ((avReq.read || avReq.write) && !ackPend)
         begin
            ackPend     <= 1'b1;
            waitrequest <= 1'b0;
            if (avReq.write)
            begin
               unique case (avReq.address)
                  REG_FLAGS:
                  begin
                     cmdOp <= aluop_t'(avReq.writedata[3:0]);
                     cmdGo <= 1'b1;
                  end
                  REG_OPA: opA <= avReq.writedata[7:0];
                  REG_OPB: opB <= avReq.writedata[7:0];
                  default: ;
               endcase
            end
            unique case (avReq.address)
               REG_FLAGS: readdata <= {24'h00_0000, conditionFlags};
               REG_PC:    readdata <= {16'h0000, programCounter};
               REG_OPA:   readdata <= {16'h0000, lastResult, opA};
               REG_OPB:   readdata <= {24'h00_0000, opB};
               default:   readdata <= 32'h0000_0000;
            endcase
         end
         else
         begin
            ackPend     <= 1'b0;
            waitrequest <= 1'b1;
         end
      end
   end

   // alu and flag generation
   always_comb
   begin
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] corr;
      sum        = 9'h000;
      low        = 5'h00;
      corr       = 8'h00;
      next_flags = conditionFlags;
      alu.data   = 8'h00;
      alu.result = 8'h00;
      unique case (cmdOp)
         OP_ADD, OP_ADC:
         begin
            low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]}
                + {4'h0, (cmdOp == OP_ADC) & conditionFlags[FLAG_CARRY]};
            sum = {1'b0, opA} + {1'b0, opB}
                + {8'h00, (cmdOp == OP_ADC) & conditionFlags[FLAG_CARRY]};
            next_flags[FLAG_HALF]  = low[4];
            next_flags[FLAG_CARRY] = sum[8];
            next_flags[FLAG_OVF]   = (opA[7] == opB[7])
                                   && (sum[7] != opA[7]);
         end
         OP_SUB:
         begin
            sum = {1'b0, opA} - {1'b0, opB};
            next_flags[FLAG_CARRY] = sum[8];
            next_flags[FLAG_OVF]   = (opA[7] != opB[7])
                                   && (sum[7] != opA[7]);
         end
         OP_AND:
         begin
            sum = {1'b0, opA & opB};
            next_flags[FLAG_OVF] = 1'b0;
         end
         OP_LOAD8, OP_LOAD16:
         begin
            sum = {1'b0, opA};
            next_flags[FLAG_OVF] = 1'b0;
         end
         OP_DAA:
         begin
            if (conditionFlags[FLAG_HALF] || (opA[3:0] > 4'h9))
               corr[3:0] = 4'h6;
            if (conditionFlags[FLAG_CARRY] || (opA > 8'h99))
               corr[7:4] = 4'h6;
            sum = {1'b0, opA} + {1'b0, corr};
            next_flags[FLAG_CARRY] = conditionFlags[FLAG_CARRY]
                                   | (corr[7:4] == 4'h6);
         end
         OP_SHL:
         begin
            sum = {opA, 1'b0};
            next_flags[FLAG_CARRY] = opA[7];
         end
         OP_SHR:
         begin
            sum = {1'b0, 1'b0, opA[7:1]};
            next_flags[FLAG_CARRY] = opA[0];
         end
         OP_CLRM: next_flags[FLAG_MASK] = 1'b0;
         OP_SETM: next_flags[FLAG_MASK] = 1'b1;
         OP_TAP:  next_flags = opA;
         default: ;
      endcase
      alu.result = sum[7:0];
      alu.data   = opB;
      if (cmdOp inside {OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_DAA,
                        OP_SHL, OP_SHR, OP_LOAD8})
      begin
         next_flags[FLAG_NEG]  = sum[7];
         next_flags[FLAG_ZERO] = (sum[7:0] == 8'h00);
      end
      else if (cmdOp == OP_LOAD16)
      begin
         next_flags[FLAG_NEG]  = opB[7];
         next_flags[FLAG_ZERO] = ({opB, opA} == 16'h0000);
      end
      next_flags = fixFlags(next_flags);
   end

   // result frozen when its command runs, so later flag changes cannot alter it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         lastResult <= 8'h00;
      else if (cmdGo)
         lastResult <= alu.result;
   end

   // interrupt gating: blocked one boundary after the mask is cleared
   assign canIrq = irqReq && !conditionFlags[FLAG_MASK]
                && !maskShadow;

   // flags register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         conditionFlags <= FLAGS_RESET;
         maskShadow     <= 1'b0;
      end
      else
      begin
         if (state == S_PUSH && pushIdx == 3'd4)
            conditionFlags[FLAG_MASK] <= 1'b1;
         else if (cmdGo)
            conditionFlags <= next_flags;
         if (cmdGo && conditionFlags[FLAG_MASK]
             && !next_flags[FLAG_MASK])
            maskShadow <= 1'b1;
         else if (state == S_RUN && pcOp == PCOP_INC)
            maskShadow <= 1'b0;
      end
   end

   // program counter sequencer
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state          <= S_VECHI;
         programCounter <= PC_RESET;
         busAddr        <= RESET_VECTOR_HI_ADDR;
         busRead        <= 1'b1;
         busWrite       <= 1'b0;
         busWdata       <= 8'h00;
         vecHigh        <= 8'h00;
         pushIdx        <= 3'd0;
         irqTaken       <= 1'b0;
         busy           <= 1'b1;
      end
      else
      begin
         irqTaken <= 1'b0;
         unique case (state)
            S_VECHI:
            begin
               vecHigh <= busRdata;
               busAddr <= RESET_VECTOR_LO_ADDR;
               state   <= S_VECLO;
            end
            S_VECLO:
            begin
               programCounter <= {vecHigh, busRdata};
               busAddr        <= {vecHigh, busRdata};
               busRead        <= 1'b1;
               busy           <= 1'b0;
               state          <= S_RUN;
            end
            S_RUN:
            begin
               if (canIrq && pcOp == PCOP_INC)
               begin
                  busy     <= 1'b1;
                  pushIdx  <= 3'd0;
                  busRead  <= 1'b0;
                  busWrite <= 1'b1;
                  busAddr  <= stackPtr;
                  busWdata <= programCounter[7:0];
                  state    <= S_PUSH;
               end
               else
               begin
                  unique case (pcOp)
                     PCOP_INC:
                        programCounter <= programCounter + 16'h0001;
                     PCOP_LOAD, PCOP_INT:
                        programCounter <= pcTarget;
                     PCOP_REL:
                        if (branchCond)
                           programCounter <= programCounter
                                           + sext8(relOffset);
                     default: ;
                  endcase
                  busAddr <= programCounter;
                  busRead <= (pcOp == PCOP_INC);
               end
            end
            S_PUSH:
            begin
               pushIdx <= pushIdx + 3'd1;
               busAddr <= busAddr - 16'h0001;
               unique case (pushIdx)
                  3'd0: busWdata <= programCounter[15:8];
                  3'd1: busWdata <= indexLow;
                  3'd2: busWdata <= accum;
                  3'd3: busWdata <= conditionFlags;
                  default:
                  begin
                     busWrite <= 1'b0;
                     state    <= S_IVEC;
                  end
               endcase
            end
            S_IVEC:
            begin
               programCounter <= irqVector;
               busAddr        <= irqVector;
               busRead        <= 1'b1;
               irqTaken       <= 1'b1;
               busy           <= 1'b0;
               state          <= S_RUN;
            end
            default: state <= S_RUN;
         endcase
      end
   end

   // signed branch conditions from overflow, negative and zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         signedGreater <= 1'b0;
         signedLess    <= 1'b0;
      end
      else
      begin
         signedLess    <= conditionFlags[FLAG_NEG]
                        ^ conditionFlags[FLAG_OVF];
         signedGreater <= !conditionFlags[FLAG_ZERO]
                        && !(conditionFlags[FLAG_NEG]
                        ^ conditionFlags[FLAG_OVF]);
      end
   end

   // inherent, move and test-branch modes are sequenced by the decoder:
   // operands arrive on registers source and destination use
   // separate address sources tested branches use pcOp PCOP_REL

   a_fixed_ones: assert property (@(posedge mclk) disable iff (rst)
      conditionFlags[6:5] == 2'b11)
      else $error("fixed flag bits not one");

   a_pc_increment: assert property (@(posedge mclk) disable iff (rst)
      (state == S_RUN && pcOp == PCOP_INC && !canIrq)
      |=> programCounter == $past(programCounter) + 16'h0001)
      else $error("counter did not advance");

   a_mask_set_irq: assert property (@(posedge mclk) disable iff (rst)
      irqTaken |-> conditionFlags[FLAG_MASK])
      else $error("mask clear after interrupt entry");

   a_irq_shadow: assert property (@(posedge mclk) disable iff (rst)
      (state == S_RUN && maskShadow) |=> state != S_PUSH)
      else $error("interrupt taken in shadow");

   a_reset_vector: assert property (@(posedge mclk) disable iff (rst)
      state == S_VECLO |=> programCounter == {$past(vecHigh),
                                              $past(busRdata)})
      else $error("reset vector misloaded");

   a_rel_branch: assert property (@(posedge mclk) disable iff (rst)
      (state == S_RUN && pcOp == PCOP_REL && branchCond && !canIrq)
      |=> programCounter == $past(programCounter)
                          + sext8($past(relOffset)))
      else $error("branch target wrong");

   sequence push_burst;
      busWrite [*5] ##1 !busWrite;
   endsequence

   a_push_count: assert property (@(posedge mclk) disable iff (rst)
      $rose(state == S_PUSH) |-> push_burst)
      else $error("push length wrong");

   a_jump_load: assert property (@(posedge mclk) disable iff (rst)
      (state == S_RUN && pcOp == PCOP_LOAD && !canIrq)
      |=> programCounter == $past(pcTarget))
      else $error("jump target not loaded");
endmodule : cpu_pc_flags_datapath
`default_nettype wire

// file: pcflags_pkg.sv
// package: constants and types for the program counter and flags datapath
package pcflags_pkg;
   localparam logic [15:0] RESET_VECTOR_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] RESET_VECTOR_LO_ADDR = 16'hFFFF;
   localparam logic [15:0] PC_RESET             = 16'h0000;
   localparam logic [7:0]  FLAGS_RESET          = 8'h68;
   localparam int          FLAG_OVF             = 7;
   localparam int          FLAG_ONE6            = 6;
   localparam int          FLAG_ONE5            = 5;
   localparam int          FLAG_HALF            = 4;
   localparam int          FLAG_MASK            = 3;
   localparam int          FLAG_NEG             = 2;
   localparam int          FLAG_ZERO            = 1;
   localparam int          FLAG_CARRY           = 0;
   localparam logic [7:0]  FLAGS_FIXED_ONES     = 8'h60;
   // register map (byte addresses, one word each)
   localparam logic [3:0]  REG_FLAGS            = 4'h0;
   localparam logic [3:0]  REG_PC               = 4'h4;
   localparam logic [3:0]  REG_OPA              = 4'h8;
   localparam logic [3:0]  REG_OPB              = 4'hC;
   // command register layout
   localparam logic [3:0]  REG_CMD              = 4'h0;

   typedef enum logic [3:0]
   {
      OP_NONE  = 4'h0,
      OP_ADD   = 4'h1,
      OP_ADC   = 4'h2,
      OP_SUB   = 4'h3,
      OP_AND   = 4'h4,
      OP_LOAD8 = 4'h5,
      OP_LOAD16= 4'h6,
      OP_DAA   = 4'h7,
      OP_SHL   = 4'h8,
      OP_SHR   = 4'h9,
      OP_CLRM  = 4'hA,
      OP_SETM  = 4'hB,
      OP_TAP   = 4'hC
   } aluop_t;

   typedef enum logic [2:0]
   {
      PCOP_HOLD = 3'h0,
      PCOP_INC  = 3'h1,
      PCOP_LOAD = 3'h2,
      PCOP_REL  = 3'h3,
      PCOP_INT  = 3'h4
   } pcop_t;

   typedef struct packed
   {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } avreq_t;

   typedef struct packed
   {
      logic [7:0] data;
      logic [7:0] result;
   } aluout_t;
endpackage : pcflags_pkg

// file: bus_memory_model.sv
// behavioural memory standing on the cpu bus side of the datapath
`timescale 1ns/10ps
`default_nettype none
module bus_memory_model
#(
   parameter logic [15:0] START = 16'h1234
)
(
   // clock
   input  wire logic        mclk,
   // cpu bus
   input  wire logic [15:0] busAddr,
   input  wire logic        busRead,
   input  wire logic        busWrite,
   input  wire logic [7:0]  busWdata,
   output logic      [7:0]  busRdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] lastData;

   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      mem[16'hFFFE] = START[15:8];
      mem[16'hFFFF] = START[7:0];
      lastData = 8'h00;
   end

   // idle bus shows the inverse of the last byte, never a stale copy
   assign busRdata = busRead ? mem[busAddr] : ~lastData;

   always @(posedge mclk)
   begin
      if (busRead)
         lastData <= mem[busAddr];
      if (busWrite)
         mem[busAddr] <= busWdata;
   end
endmodule : bus_memory_model
`default_nettype wire

// file: cpu_pc_flags_datapath_tb_top.sv
// self-checking testbench for the program counter and flags datapath
`timescale 1ns/10ps
`default_nettype none
module cpu_pc_flags_datapath_tb_top;
   import pcflags_pkg::*;
   localparam logic [15:0] START = 16'h1234;
   localparam logic [15:0] SP    = 16'h0180;
   localparam logic [15:0] ISR   = 16'hC040;
   typedef struct packed
   {
      aluop_t     op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] care;
      logic [7:0] flg;
      logic       chk;
      logic [7:0] res;
   } vec_t;
   logic        mclk;
   logic        rst;
   avreq_t      avReq;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [15:0] busAddr;
   logic        busRead;
   logic        busWrite;
   logic [7:0]  busWdata;
   logic [7:0]  busRdata;
   pcop_t       pcOp;
   logic [15:0] pcTarget;
   logic [7:0]  relOffset;
   logic        branchCond;
   logic        irqReq;
   logic [15:0] programCounter;
   logic [7:0]  conditionFlags;
   logic        irqTaken;
   logic        signedGreater;
   logic        signedLess;
   logic        busy;
   int          errors;
   int          comparisons;
   int          seenIrq;
   logic [31:0] rd;
   logic [15:0] pcHold;
   vec_t        vecs [16];

   cpu_pc_flags_datapath dut (.mclk(mclk), .rst(rst), .avReq(avReq),
      .readdata(readdata), .waitrequest(waitrequest), .busAddr(busAddr),
      .busRead(busRead), .busWrite(busWrite), .busWdata(busWdata),
      .busRdata(busRdata), .pcOp(pcOp), .pcTarget(pcTarget),
      .relOffset(relOffset), .branchCond(branchCond), .irqReq(irqReq),
      .irqVector(ISR), .indexLow(8'h5A), .accum(8'hA5), .stackPtr(SP),
      .programCounter(programCounter), .conditionFlags(conditionFlags),
      .irqTaken(irqTaken), .signedGreater(signedGreater),
      .signedLess(signedLess), .busy(busy));

   bus_memory_model #(.START(START)) memory (.mclk(mclk), .busAddr(busAddr),
      .busRead(busRead), .busWrite(busWrite), .busWdata(busWdata),
      .busRdata(busRdata));

   initial
   begin
      mclk = 1'b0;
      forever
         #50 mclk = ~mclk;
   end

   always @(negedge mclk)
      if (irqTaken === 1'b1)
         seenIrq++;

   task automatic end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic av(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge mclk);
      avReq <= '{read: !wr, write: wr, address: a, writedata: d};
      for (n = 0; n < 20; n++)
      begin
         @(posedge mclk);
         if (waitrequest === 1'b0)
            break;
      end
      rd = readdata;
      avReq <= '0;
      if (n == 20)
      begin
         errors++;
         end_of_test();
      end
   endtask : av

   task automatic rdchk(input logic [3:0] a, input logic [31:0] care,
                        input logic [31:0] exp);
      av(1'b0, a, 32'h0000_0000);
      check(rd & care, exp);
   endtask : rdchk

   task automatic alu(input aluop_t op, input logic [7:0] a,
                      input logic [7:0] b);
      av(1'b1, REG_OPA, {24'h00_0000, a});
      av(1'b1, REG_OPB, {24'h00_0000, b});
      av(1'b1, REG_CMD, {28'h000_0000, op});
   endtask : alu

   task automatic step(input pcop_t op);
      int n;
      @(posedge mclk);
      pcOp <= op;
      @(posedge mclk);
      pcOp <= PCOP_HOLD;
      for (n = 0; n < 50; n++)
      begin
         @(posedge mclk);
         if (busy === 1'b0)
            break;
      end
      if (n == 50)
      begin
         errors++;
         end_of_test();
      end
   endtask : step

   initial
   begin
      rst = 1'b1;
      avReq = '0;
      pcOp = PCOP_HOLD;
      pcTarget = 16'h0000;
      relOffset = 8'h00;
      branchCond = 1'b0;
      irqReq = 1'b0;
      errors = 0;
      comparisons = 0;
      seenIrq = 0;
      vecs = '{'{OP_ADD, 8'h08, 8'h08, 8'hFF, 8'h78, 1'b1, 8'h10},
               '{OP_ADD, 8'h7F, 8'h01, 8'hFF, 8'hFC, 1'b1, 8'h80},
               '{OP_ADD, 8'hFF, 8'h01, 8'hFF, 8'h7B, 1'b1, 8'h00},
               '{OP_ADC, 8'h01, 8'h01, 8'hFF, 8'h68, 1'b1, 8'h03},
               '{OP_SUB, 8'h00, 8'h01, 8'hEF, 8'h6D, 1'b1, 8'hFF},
               '{OP_AND, 8'hF0, 8'h0F, 8'h66, 8'h62, 1'b1, 8'h00},
               '{OP_LOAD8, 8'h80, 8'h00, 8'h66, 8'h64, 1'b0, 8'h00},
               '{OP_LOAD16, 8'h00, 8'h00, 8'h66, 8'h62, 1'b0, 8'h00},
               '{OP_LOAD16, 8'h00, 8'h80, 8'h66, 8'h64, 1'b0, 8'h00},
               '{OP_ADD, 8'h09, 8'h08, 8'hFF, 8'h78, 1'b1, 8'h11},
               '{OP_DAA, 8'h11, 8'h00, 8'h60, 8'h60, 1'b1, 8'h17},
               '{OP_ADD, 8'h15, 8'h27, 8'hFF, 8'h68, 1'b1, 8'h3C},
               '{OP_DAA, 8'h3C, 8'h00, 8'h60, 8'h60, 1'b1, 8'h42},
               '{OP_SHL, 8'h81, 8'h00, 8'h61, 8'h61, 1'b1, 8'h02},
               '{OP_SHR, 8'h01, 8'h00, 8'h63, 8'h63, 1'b1, 8'h00},
               '{OP_SHR, 8'h02, 8'h00, 8'h61, 8'h60, 1'b1, 8'h01}};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      step(PCOP_HOLD);
      check(programCounter, START);
      rdchk(REG_FLAGS, 32'h0000_00FF, 32'h0000_0068);
      rdchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
      // writes to the counter register are ignored
      av(1'b1, REG_PC, 32'h0000_5555);
      rdchk(REG_PC, 32'h0000_FFFF, {16'h0000, START});
      step(PCOP_INC);
      check(programCounter, START + 16'h0001);
      pcTarget <= 16'hFFFF;
      step(PCOP_LOAD);
      check(programCounter, 16'hFFFF);
      step(PCOP_INC);
      check(programCounter, 16'h0000);
      pcTarget <= 16'h2000;
      step(PCOP_LOAD);
      relOffset <= 8'hFE;
      branchCond <= 1'b1;
      step(PCOP_REL);
      check(programCounter, 16'h1FFE);
      relOffset <= 8'h7F;
      step(PCOP_REL);
      check(programCounter, 16'h207D);
      foreach (vecs[i])
      begin
         alu(vecs[i].op, vecs[i].a, vecs[i].b);
         rdchk(REG_FLAGS, {24'h0, vecs[i].care}, {24'h0, vecs[i].flg});
         if (vecs[i].chk)
            rdchk(REG_OPA, 32'h0000_FF00, {16'h0, vecs[i].res, 8'h0});
      end
      alu(OP_ADD, 8'h7F, 8'h01);
      step(PCOP_HOLD);
      check({signedGreater, signedLess}, 2'b10);
      alu(OP_SUB, 8'h00, 8'h01);
      step(PCOP_HOLD);
      check({signedGreater, signedLess}, 2'b01);
      alu(OP_SETM, 8'h00, 8'h00);
      irqReq <= 1'b1;
      step(PCOP_INC);
      check(seenIrq, 0);
      alu(OP_CLRM, 8'h00, 8'h00);
      rdchk(REG_FLAGS, 32'h0000_0008, 32'h0000_0000);
      pcHold = programCounter + 16'h0001;
      step(PCOP_INC);
      check(seenIrq, 0);
      check(programCounter, pcHold);
      step(PCOP_INC);
      irqReq <= 1'b0;
      check(seenIrq, 1);
      check(programCounter, ISR);
      check(conditionFlags[FLAG_MASK], 1'b1);
      check(memory.mem[SP], pcHold[7:0]);
      check(memory.mem[SP - 16'h0001], pcHold[15:8]);
      check(memory.mem[SP - 16'h0002], 8'h5A);
      check(memory.mem[SP - 16'h0003], 8'hA5);
      check(memory.mem[SP - 16'h0004] & 8'h68, 8'h60);
      alu(OP_TAP, 8'h00, 8'h00);
      rdchk(REG_FLAGS, 32'h0000_00FF, 32'h0000_0060);
      pcTarget <= 16'h4321;
      step(PCOP_INT);
      check(programCounter, 16'h4321);
      end_of_test();
   end
endmodule : cpu_pc_flags_datapath_tb_top
`default_nettype wire
